//--- rtl/dwell_pkg.sv
package dwell_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int DUR_W = 14;
    localparam int GAG_W = 4;
    localparam int CFG_W = 8;
    localparam int TICK_W = 16;

    // ----------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CUT_DOWN = 8'h04;
    localparam logic [7:0] OFS_CUT_UP = 8'h08;
    localparam logic [7:0] OFS_PUNCH_DOWN = 8'h0C;
    localparam logic [7:0] OFS_PUNCH_UP = 8'h10;
    localparam logic [7:0] OFS_TOOL_SEL = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;

    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int CTRL_SETUP_BIT = 0;
    localparam int CFG_CUT_BOOST_BIT = 0;
    localparam int CFG_PUNCH_BOOST_BIT = 1;
    localparam int CFG_TWO_SPEED_BIT = 2;
    localparam int ST_CUT_BUSY_BIT = 0;
    localparam int ST_PUNCH_BUSY_BIT = 1;
    localparam int ST_SETUP_BIT = 2;
    localparam int ST_CFG_LSB = 8;

    // ----------------------------------------
    // Reset values and limits
    // ----------------------------------------
    localparam logic [DUR_W-1:0] DUR_RST = 14'h0000;
    localparam logic [DUR_W-1:0] DUR_MAX = 14'h270F;
    localparam logic [GAG_W-1:0] GAG_RST = 4'h0;
    localparam logic [DATA_W-1:0] RDATA_NONE = 32'h00000000;

    // ----------------------------------------
    // Timing: one duration step is one millisecond
    // ----------------------------------------
    localparam int unsigned CLK_PERIOD_PS = 25000;
    localparam int unsigned DUR_STEP_PS = 1000000000;
    localparam int unsigned MS_TICK_CYCLES = DUR_STEP_PS / CLK_PERIOD_PS;

endpackage

//--- rtl/pin_sync.sv
`timescale 1ns/1ps
module pin_sync import dwell_pkg::*; #(
    parameter int W = 1
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_state_type;

    sync_state_type st_q;
    sync_state_type st_d;

    // First stage feeds only the second stage
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.s1 = d;
            st_d.s2 = st_q.s1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.s2;

endmodule

//--- rtl/stroke_timer.sv
`timescale 1ns/1ps
module stroke_timer import dwell_pkg::*; (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic tick,
    input wire logic fire,
    input wire logic complete,
    input wire logic boost_sel,
    input wire logic [DUR_W-1:0] down_ms,
    input wire logic [DUR_W-1:0] up_ms,
    output logic down_out,
    output logic up_out,
    output logic boost_out,
    output logic busy
);

    typedef enum logic [1:0] {
        S_IDLE,
        S_DOWN,
        S_AFTER
    } phase_type;

    typedef struct packed {
        phase_type phase;
        logic boost;
        logic [DUR_W-1:0] cnt;
    } timer_state_type;

    timer_state_type st_q;
    timer_state_type st_d;

    always_comb begin
        st_d = st_q;
        if (ce) begin
            unique case (st_q.phase)
                S_IDLE: begin
                    if (fire) begin
                        st_d.boost = boost_sel;
                        if (down_ms != DUR_RST) begin
                            st_d.phase = S_DOWN;
                            st_d.cnt = down_ms;
                        end else if (up_ms != DUR_RST) begin
                            st_d.phase = S_AFTER;
                            st_d.cnt = up_ms;
                        end
                    end
                end
                S_DOWN: begin
                    // Switch closure cuts the dwell short; the timer is only a backstop
                    if (complete || (tick && st_q.cnt == 14'h0001)) begin
                        if (up_ms != DUR_RST) begin
                            st_d.phase = S_AFTER;
                            st_d.cnt = up_ms;
                        end else begin
                            st_d.phase = S_IDLE;
                        end
                    end else if (tick) begin
                        st_d.cnt = st_q.cnt - 14'h0001;
                    end
                end
                S_AFTER: begin
                    // Return stroke runs its full time whatever the switch says
                    if (tick) begin
                        if (st_q.cnt == 14'h0001) begin
                            st_d.phase = S_IDLE;
                        end else begin
                            st_d.cnt = st_q.cnt - 14'h0001;
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{phase: S_IDLE, boost: 1'b0, cnt: DUR_RST};
        end else begin
            st_q <= st_d;
        end
    end

    assign down_out = (st_q.phase == S_DOWN);
    assign up_out = (st_q.phase == S_AFTER) && !st_q.boost;
    assign boost_out = (st_q.phase == S_AFTER) && st_q.boost;
    assign busy = (st_q.phase != S_IDLE);

    chk_complete_ends_down: assert property (@(posedge clk_sys) disable iff (!nrst)
        (down_out && complete && ce) |=> !down_out) else $error("down stroke kept after complete");

    chk_after_ignores_complete: assert property (@(posedge clk_sys) disable iff (!nrst)
        ((up_out || boost_out) && !tick && ce) |=> (up_out || boost_out)) else $error("after pulse cut");

    chk_after_follows_down: assert property (@(posedge clk_sys) disable iff (!nrst)
        ($fell(down_out) && $past(up_ms) != DUR_RST) |-> (up_out || boost_out)) else $error("no after pulse");

    chk_after_exclusive: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(up_out && boost_out) && !(down_out && (up_out || boost_out))) else $error("outputs overlap");

    chk_fire_starts_down: assert property (@(posedge clk_sys) disable iff (!nrst)
        (!busy && fire && ce && down_ms != DUR_RST) |=> (down_out && st_q.cnt == $past(down_ms)))
        else $error("down stroke not started");

endmodule

//--- rtl/cut_press_dwell_timer.sv
`timescale 1ns/1ps
// Contract
// - Cutoff down pulse lasts programmed 0 to 9.999 s
// - Cutoff complete switch ends down pulse at once
// - Cutoff up pulse runs full length regardless
// - Cutoff up or boost output chosen by config
// - Punch down pulse programmable like cutoff
// - Punch complete switch ends punch down pulse
// - Punch up or boost output chosen by config
// - Manual cutoff input fires cutoff down pulse
// - Manual punch selects tool gag then fires
// - Two-speed machines always jog at slow speed
// - Changed config switches erase memory, enter setup
// - Down durations have one millisecond resolution
module cut_press_dwell_timer import dwell_pkg::*; #(
    parameter int unsigned MS_CYCLES = MS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic ce,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [DATA_W-1:0] rdata,
    input wire logic [CFG_W-1:0] cfg_sw,
    input wire logic man_cut,
    input wire logic man_punch,
    input wire logic cut_done_sw,
    input wire logic punch_done_sw,
    input wire logic jog_fwd,
    input wire logic jog_rev,
    input wire logic run_on,
    input wire logic run_fast,
    input wire logic cut_fire,
    input wire logic punch_fire,
    input wire logic [GAG_W-1:0] auto_gag,
    output logic cut_down,
    output logic cut_up,
    output logic cut_boost,
    output logic punch_down,
    output logic punch_up,
    output logic punch_boost,
    output logic [GAG_W-1:0] gag_sel,
    output logic fwd_out,
    output logic slow_out,
    output logic rev_out,
    output logic setup_mode
);

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    localparam int PIN_W = CFG_W + 6;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s;
    logic [CFG_W-1:0] cfg_s;
    logic man_cut_s;
    logic man_punch_s;
    logic cut_done_s;
    logic punch_done_s;
    logic jog_fwd_s;
    logic jog_rev_s;

    assign pin_raw = {cfg_sw, man_cut, man_punch, cut_done_sw, punch_done_sw, jog_fwd, jog_rev};

    pin_sync #(.W(PIN_W)) u_pin_sync (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .d(pin_raw),
        .q(pin_s)
    );

    assign cfg_s = pin_s[PIN_W-1:6];
    assign man_cut_s = pin_s[5];
    assign man_punch_s = pin_s[4];
    assign cut_done_s = pin_s[3];
    assign punch_done_s = pin_s[2];
    assign jog_fwd_s = pin_s[1];
    assign jog_rev_s = pin_s[0];

    // ----------------------------------------
    // State
    // ----------------------------------------
    typedef struct packed {
        logic [CFG_W-1:0] cfg_ref;
        logic cfg_valid;
        logic setup;
        logic [DUR_W-1:0] cut_dn;
        logic [DUR_W-1:0] cut_up;
        logic [DUR_W-1:0] pun_dn;
        logic [DUR_W-1:0] pun_up;
        logic [GAG_W-1:0] tool_sel;
        logic [GAG_W-1:0] gag;
        logic man_cut_prev;
        logic man_punch_prev;
        logic [TICK_W-1:0] ms_cnt;
        logic tick;
        logic [DATA_W-1:0] rdata;
        logic fwd;
        logic slow;
        logic rev;
    } top_state_type;

    top_state_type st_q;
    top_state_type st_d;

    logic cut_busy;
    logic punch_busy;
    logic man_cut_edge;
    logic man_punch_edge;
    logic cfg_changed;
    logic cut_go;
    logic punch_go;
    logic two_speed;

    // Durations above the top of the range are held at the top
    function automatic logic [DUR_W-1:0] clamp_dur(input logic [DATA_W-1:0] v);
        if (v > {18'h00000, DUR_MAX}) begin
            return DUR_MAX;
        end
        return v[DUR_W-1:0];
    endfunction

    function automatic logic [DATA_W-1:0] widen_dur(input logic [DUR_W-1:0] v);
        return {18'h00000, v};
    endfunction

    assign man_cut_edge = man_cut_s && !st_q.man_cut_prev;
    assign man_punch_edge = man_punch_s && !st_q.man_punch_prev;
    assign cfg_changed = st_q.cfg_valid && (cfg_s != st_q.cfg_ref);
    assign two_speed = cfg_s[CFG_TWO_SPEED_BIT];
    // No firing while setup is pending: the durations were just wiped
    assign cut_go = ce && !st_q.setup && (cut_fire || man_cut_edge);
    assign punch_go = ce && !st_q.setup && (punch_fire || man_punch_edge);

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        st_d = st_q;
        if (ce) begin
            st_d.man_cut_prev = man_cut_s;
            st_d.man_punch_prev = man_punch_s;

            // Millisecond time base
            st_d.tick = 1'b0;
            if (st_q.ms_cnt == TICK_W'(MS_CYCLES - 1)) begin
                st_d.ms_cnt = '0;
                st_d.tick = 1'b1;
            end else begin
                st_d.ms_cnt = st_q.ms_cnt + 16'h0001;
            end

            // Register writes
            if (wr_stb) begin
                unique case (addr)
                    OFS_CTRL: begin
                        if (wdata[CTRL_SETUP_BIT]) begin
                            st_d.setup = 1'b0;
                        end
                    end
                    OFS_CUT_DOWN: st_d.cut_dn = clamp_dur(wdata);
                    OFS_CUT_UP: st_d.cut_up = clamp_dur(wdata);
                    OFS_PUNCH_DOWN: st_d.pun_dn = clamp_dur(wdata);
                    OFS_PUNCH_UP: st_d.pun_up = clamp_dur(wdata);
                    OFS_TOOL_SEL: st_d.tool_sel = wdata[GAG_W-1:0];
                    default: begin
                    end
                endcase
            end

            // Register reads, answered in the next cycle
            st_d.rdata = RDATA_NONE;
            if (rd_stb) begin
                unique case (addr)
                    OFS_CTRL: st_d.rdata[CTRL_SETUP_BIT] = st_q.setup;
                    OFS_CUT_DOWN: st_d.rdata = widen_dur(st_q.cut_dn);
                    OFS_CUT_UP: st_d.rdata = widen_dur(st_q.cut_up);
                    OFS_PUNCH_DOWN: st_d.rdata = widen_dur(st_q.pun_dn);
                    OFS_PUNCH_UP: st_d.rdata = widen_dur(st_q.pun_up);
                    OFS_TOOL_SEL: st_d.rdata[GAG_W-1:0] = st_q.tool_sel;
                    OFS_STATUS: begin
                        st_d.rdata[ST_CUT_BUSY_BIT] = cut_busy;
                        st_d.rdata[ST_PUNCH_BUSY_BIT] = punch_busy;
                        st_d.rdata[ST_SETUP_BIT] = st_q.setup;
                        st_d.rdata[ST_CFG_LSB +: CFG_W] = cfg_s;
                    end
                    default: st_d.rdata = RDATA_NONE;
                endcase
            end

            // Gag choice is latched when the punch fires
            if (punch_go && !punch_busy) begin
                st_d.gag = man_punch_edge ? st_q.tool_sel : auto_gag;
            end

            // Drive outputs per speed logic; jog never goes fast on two-speed lines
            st_d.rev = jog_rev_s && !run_on;
            if (run_on) begin
                st_d.fwd = two_speed ? run_fast : 1'b1;
                st_d.slow = two_speed ? !run_fast : !run_fast;
            end else if (jog_fwd_s) begin
                st_d.fwd = !two_speed;
                st_d.slow = 1'b1;
            end else if (jog_rev_s) begin
                st_d.fwd = 1'b0;
                st_d.slow = 1'b1;
            end else begin
                st_d.fwd = 1'b0;
                st_d.slow = !two_speed;
            end

            // Reference taken in the first enabled cycle after reset, from the synchroniser's reset zeros
            if (!st_q.cfg_valid) begin
                st_d.cfg_valid = 1'b1;
                st_d.cfg_ref = cfg_s;
            end else if (cfg_changed) begin
                // Erase wins over a write in the same cycle
                st_d.cfg_ref = cfg_s;
                st_d.setup = 1'b1;
                st_d.cut_dn = DUR_RST;
                st_d.cut_up = DUR_RST;
                st_d.pun_dn = DUR_RST;
                st_d.pun_up = DUR_RST;
                st_d.tool_sel = GAG_RST;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // ----------------------------------------
    // Tool timers
    // ----------------------------------------
    stroke_timer u_cut_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .tick(st_q.tick),
        .fire(cut_go),
        .complete(cut_done_s),
        .boost_sel(cfg_s[CFG_CUT_BOOST_BIT]),
        .down_ms(st_q.cut_dn),
        .up_ms(st_q.cut_up),
        .down_out(cut_down),
        .up_out(cut_up),
        .boost_out(cut_boost),
        .busy(cut_busy)
    );

    stroke_timer u_punch_timer (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .ce(ce),
        .tick(st_q.tick),
        .fire(punch_go),
        .complete(punch_done_s),
        .boost_sel(cfg_s[CFG_PUNCH_BOOST_BIT]),
        .down_ms(st_q.pun_dn),
        .up_ms(st_q.pun_up),
        .down_out(punch_down),
        .up_out(punch_up),
        .boost_out(punch_boost),
        .busy(punch_busy)
    );

    assign rdata = st_q.rdata;
    assign gag_sel = st_q.gag;
    assign fwd_out = st_q.fwd;
    assign slow_out = st_q.slow;
    assign rev_out = st_q.rev;
    assign setup_mode = st_q.setup;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_jog_slow_only: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && two_speed && !run_on && jog_fwd_s) |=> (slow_out && !fwd_out)) else $error("fast jog");

    chk_cfg_erase: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ce && cfg_changed) |=> (setup_mode && st_q.cut_dn == DUR_RST && st_q.pun_dn == DUR_RST))
        else $error("config change not erased");

    chk_dur_range: assert property (@(posedge clk_sys) disable iff (!nrst)
        (st_q.cut_dn <= DUR_MAX && st_q.pun_dn <= DUR_MAX)) else $error("duration out of range");

    chk_manual_gag: assert property (@(posedge clk_sys) disable iff (!nrst)
        (punch_go && man_punch_edge && !punch_busy) |=> (gag_sel == $past(st_q.tool_sel)))
        else $error("wrong gag on manual punch");

    chk_manual_cut: assert property (@(posedge clk_sys) disable iff (!nrst)
        (man_cut_edge && ce && !st_q.setup && !cut_busy && st_q.cut_dn != DUR_RST) |=> cut_down)
        else $error("manual cut not fired");

    chk_punch_done: assert property (@(posedge clk_sys) disable iff (!nrst)
        (punch_down && punch_done_s && ce) |=> !punch_down) else $error("punch kept down");

endmodule

//--- verif/tool_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// Stroke-complete switch of one tool
// ----------------------------------------
module tool_model (
    input wire logic clk_sys,
    input wire logic down,
    input wire logic ret,
    input wire logic [15:0] close_after,
    output logic done_sw
);
    logic [15:0] cnt = 16'h0000;

    initial done_sw = 1'b0;

    // Closes near the bottom and stays closed while the ram returns,
    // so the return pulse really sees a closed switch; 0 means never closes
    always @(posedge clk_sys) begin
        if (down) begin
            cnt <= cnt + 16'h0001;
            if (close_after != 16'h0000 && cnt + 16'h0001 >= close_after) begin
                done_sw <= 1'b1;
            end
        end else if (!ret) begin
            cnt <= 16'h0000;
            done_sw <= 1'b0;
        end
    end
endmodule

//--- verif/cut_press_dwell_timer_tb.sv
`timescale 1ns/1ps
module cut_press_dwell_timer_tb import dwell_pkg::*;;
    // Short millisecond base keeps every stroke to a few dozen cycles
    localparam int MS = 4;
    logic clk_sys = 1'b0;
    logic nrst, ce, wr_stb, rd_stb, man_cut, man_punch, jog_fwd, jog_rev;
    logic run_on, run_fast, cut_fire, punch_fire, cut_done_sw, punch_done_sw;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata, rd_val;
    logic [CFG_W-1:0] cfg_sw;
    logic [GAG_W-1:0] auto_gag, gag_sel;
    logic cut_down, cut_up, cut_boost, punch_down, punch_up, punch_boost;
    logic fwd_out, slow_out, rev_out, setup_mode;
    logic [15:0] cut_close, punch_close;
    logic [5:0] outs, seen;
    int err_count = 0;
    int n_compared = 0;
    int cycles = 0;
    int n;

    assign outs = {punch_boost, punch_up, punch_down, cut_boost, cut_up, cut_down};
    always #12.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) seen <= seen | outs;

    cut_press_dwell_timer #(.MS_CYCLES(MS)) dut (.clk_sys(clk_sys), .nrst(nrst), .ce(ce), .addr(addr),
        .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cfg_sw(cfg_sw), .man_cut(man_cut),
        .man_punch(man_punch), .cut_done_sw(cut_done_sw), .punch_done_sw(punch_done_sw), .jog_fwd(jog_fwd),
        .jog_rev(jog_rev), .run_on(run_on), .run_fast(run_fast), .cut_fire(cut_fire), .punch_fire(punch_fire),
        .auto_gag(auto_gag), .cut_down(cut_down), .cut_up(cut_up), .cut_boost(cut_boost),
        .punch_down(punch_down), .punch_up(punch_up), .punch_boost(punch_boost), .gag_sel(gag_sel),
        .fwd_out(fwd_out), .slow_out(slow_out), .rev_out(rev_out), .setup_mode(setup_mode));
    tool_model cut_tool (.clk_sys(clk_sys), .down(cut_down), .ret(cut_up | cut_boost),
        .close_after(cut_close), .done_sw(cut_done_sw));
    tool_model punch_tool (.clk_sys(clk_sys), .down(punch_down), .ret(punch_up | punch_boost),
        .close_after(punch_close), .done_sw(punch_done_sw));

    // ----------------------------------------
    // Checks and closing report
    // ----------------------------------------
    task automatic results();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic rng(input string name, input int lo, input int hi, input int got);
        n_compared++;
        if (got < lo || got > hi) begin
            err_count++;
            $display("unexpected %s: expected %0d..%0d, seen %0d", name, lo, hi, got);
        end
    endtask

    // Stuck bench still reaches the verdict
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            $display("unexpected run length: expected under 20000 cycles, seen %0d", cycles);
            results();
        end
    end

    // ----------------------------------------
    // Register bus and stimulus
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
    endtask

    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        chk(name, exp, rdata);
    endtask

    // 0 auto cutoff, 1 auto punch, 2 manual cutoff pin, 3 manual punch pin
    task automatic kick(input int k);
        @(posedge clk_sys);
        case (k)
            0: cut_fire <= 1'b1;
            1: punch_fire <= 1'b1;
            2: man_cut <= 1'b1;
            default: man_punch <= 1'b1;
        endcase
        @(posedge clk_sys);
        cut_fire <= 1'b0;
        punch_fire <= 1'b0;
        man_cut <= 1'b0;
        man_punch <= 1'b0;
        #1;
    endtask

    task automatic pulse(input int idx, output int len);
        int w;
        w = 0;
        len = 0;
        while (outs[idx] !== 1'b1 && w < 40) begin
            @(posedge clk_sys);
            #1;
            w++;
        end
        while (outs[idx] === 1'b1 && len < 50000) begin
            @(posedge clk_sys);
            #1;
            len++;
        end
    endtask

    // Down pulse, then the return pulse must start on the very edge it ends
    task automatic stroke(input int k, input int d, input int r, input int lo, input int hi,
                          input int ulo, input int uhi);
        kick(k);
        pulse(d, n);
        rng("down length", lo, hi, n);
        chk("return start", 32'h00000001, 32'(outs[r]));
        pulse(r, n);
        rng("return length", ulo, uhi, n);
    endtask

    task automatic mot(input logic jf, input logic jr, input logic ro, input logic rf,
                       input logic ef, input logic es, input logic er);
        @(posedge clk_sys);
        jog_fwd <= jf;
        jog_rev <= jr;
        run_on <= ro;
        run_fast <= rf;
        repeat (6) @(posedge clk_sys);
        #1;
        chk("forward", 32'(ef), 32'(fwd_out));
        chk("slow", 32'(es), 32'(slow_out));
        chk("reverse", 32'(er), 32'(rev_out));
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        {nrst, wr_stb, rd_stb, man_cut, man_punch, jog_fwd, jog_rev, run_on, run_fast} = 9'h000;
        {cut_fire, punch_fire} = 2'h0;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h00000000;
        cfg_sw = 8'h00;
        auto_gag = 4'h0;
        cut_close = 16'h0000;
        punch_close = 16'h0000;
        seen = 6'h00;
        repeat (20) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(posedge clk_sys);
        // Offset 0x1C is unmapped and must read zero too
        for (int i = 0; i < 8; i++) rdchk("reset value", 8'(i * 4), 32'h00000000);
        wr(OFS_STATUS, 32'hFFFFFFFF);
        rdchk("read-only status", OFS_STATUS, 32'h00000000);
        wr(OFS_CUT_DOWN, 32'h00002710);
        rdchk("down clamp", OFS_CUT_DOWN, {18'h00000, DUR_MAX});
        wr(OFS_CUT_DOWN, 32'h00000003);
        wr(OFS_CUT_UP, 32'h00000002);
        stroke(0, 0, 1, 9, 12, 5, 8);
        // Zero down time goes straight to the return pulse
        wr(OFS_CUT_DOWN, 32'h00000000);
        #1;
        seen = 6'h00;
        kick(0);
        pulse(1, n);
        rng("return length", 5, 8, n);
        chk("no down pulse", 32'h00000000, 32'(seen[0]));
        wr(OFS_CUT_DOWN, 32'h00000032);
        cut_close <= 16'h000A;
        stroke(0, 0, 1, 10, 16, 5, 8);
        cut_close <= 16'h0000;
        wr(OFS_CUT_DOWN, 32'h00000003);
        stroke(2, 0, 1, 9, 12, 5, 8);
        wr(OFS_PUNCH_DOWN, 32'h00000003);
        wr(OFS_PUNCH_UP, 32'h00000002);
        wr(OFS_TOOL_SEL, 32'h00000005);
        stroke(3, 3, 4, 9, 12, 5, 8);
        chk("manual gag", 32'h00000005, 32'(gag_sel));
        wr(OFS_PUNCH_DOWN, 32'h00000014);
        auto_gag <= 4'h9;
        punch_close <= 16'h0006;
        stroke(1, 3, 4, 6, 12, 5, 8);
        chk("auto gag", 32'h00000009, 32'(gag_sel));
        punch_close <= 16'h0000;
        mot(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0);
        // Switch change: boost on both tools, two speeds
        cfg_sw <= 8'h07;
        repeat (10) @(posedge clk_sys);
        #1;
        chk("setup mode", 32'h00000001, 32'(setup_mode));
        rdchk("erased down", OFS_PUNCH_DOWN, 32'h00000000);
        rdchk("erased tool", OFS_TOOL_SEL, 32'h00000000);
        rdchk("setup status", OFS_STATUS, 32'h00000704);
        seen = 6'h00;
        kick(0);
        repeat (10) @(posedge clk_sys);
        #1;
        chk("fire in setup", 32'h00000000, 32'(seen));
        wr(OFS_CTRL, 32'h00000001);
        #1;
        chk("setup cleared", 32'h00000000, 32'(setup_mode));
        wr(OFS_CUT_DOWN, 32'h00000002);
        wr(OFS_CUT_UP, 32'h00000002);
        wr(OFS_PUNCH_DOWN, 32'h00000002);
        wr(OFS_PUNCH_UP, 32'h00000002);
        #1;
        seen = 6'h00;
        stroke(0, 0, 2, 5, 8, 5, 8);
        stroke(1, 3, 5, 5, 8, 5, 8);
        chk("no up with boost", 32'h00000000, 32'({seen[4], seen[1]}));
        mot(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        mot(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1);
        mot(1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0);
        mot(1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
        // Clock enable low must swallow a register write
        ce <= 1'b0;
        wr(OFS_TOOL_SEL, 32'h00000003);
        ce <= 1'b1;
        rdchk("frozen write", OFS_TOOL_SEL, 32'h00000000);
        results();
    end
endmodule
